/* design/timer_pair_pkg.sv */
/*
 * Shared constants for the dual 16/32-bit timer pair: register indices,
 * control field positions, reset values and prescaler limits.
 * Assumes an APB master on the same clock; byte address is four times the index.
 */
`default_nettype none

package timer_pair_pkg;

	// ************************************************************
	// Register indices (byte address = index * 4)
	// ************************************************************
	localparam int ADDR_W = 12;
	localparam int CNT_W = 16;
	localparam int PSC_W = 8;
	localparam logic [9:0] IDX_LOW_COUNT_WORD = 10'h106;
	localparam logic [9:0] IDX_HIGH_WORD_HOLDING_REG = 10'h108;
	localparam logic [9:0] IDX_HIGH_COUNT_WORD = 10'h10a;
	localparam logic [9:0] IDX_LOW_PERIOD_WORD = 10'h10c;
	localparam logic [9:0] IDX_HIGH_PERIOD_WORD = 10'h10e;
	localparam logic [9:0] IDX_LOWER_TIMER_CONTROL = 10'h110;
	localparam logic [9:0] IDX_UPPER_TIMER_CONTROL = 10'h112;
	localparam logic [9:0] IDX_IRQ_FLAGS_ENABLES = 10'h120;

	// ************************************************************
	// Control fields
	// ************************************************************
	localparam int CTL_RUN_BIT = 15;
	localparam int CTL_SIDL_BIT = 13;
	localparam int CTL_GATE_BIT = 6;
	localparam int CTL_PSC_LSB = 4;
	localparam int CTL_T32_BIT = 3;
	localparam int CTL_CS_BIT = 1;
	localparam logic [15:0] LOWER_CTL_MASK = 16'ha07a;
	localparam logic [15:0] UPPER_CTL_MASK = 16'ha072;

	// ************************************************************
	// Interrupt flag and enable fields
	// ************************************************************
	localparam int IRQ_UP_FLAG_BIT = 0;
	localparam int IRQ_LO_FLAG_BIT = 1;
	localparam int IRQ_UP_EN_BIT = 8;
	localparam int IRQ_LO_EN_BIT = 9;

	// ************************************************************
	// Reset values and prescaler terminal counts
	// ************************************************************
	localparam logic [15:0] CTL_RST = 16'h0000;
	localparam logic [15:0] COUNT_RST = 16'h0000;
	localparam logic [15:0] PERIOD_RST = 16'hffff;
	localparam logic [7:0] PSC_LIM_DIV1 = 8'h00;
	localparam logic [7:0] PSC_LIM_DIV8 = 8'h07;
	localparam logic [7:0] PSC_LIM_DIV64 = 8'h3f;
	localparam logic [7:0] PSC_LIM_DIV256 = 8'hff;

	typedef enum logic [3:0] {
		SEL_NONE, SEL_LOW_CNT, SEL_HOLD, SEL_HIGH_CNT, SEL_LOW_PER,
		SEL_HIGH_PER, SEL_LOW_CTL, SEL_UP_CTL, SEL_IRQ
	} reg_sel_t;

endpackage : timer_pair_pkg

`default_nettype wire

/* design/timer_pair.sv */
/*
 * Dual 16-bit timer pair, cascadable into one 32-bit timer or counter,
 * with APB register access, gated accumulation, prescalers and ADC trigger.
 * Assumes APB master on i_mclk; idle and sleep levels come from the same clock.
 */
// The implementer's own choices: the register addresses and the APB register port.
// Summary of operation
// - 32-bit mode counts cycles, wraps at period
// - Lower word low half, upper word high half
// - 32-bit mode ignores upper control register
// - 32-bit match sets upper flag, enable gates
// - Low word read latches high word
// - Holding write then low write loads high in 32-bit mode
// - 32-bit counter counts synchronised external edges
// - Idle stops count when stop-in-idle set
// - 16-bit timers independent, no asynchronous counting
// - Only lower timer resynchronises prescaler output
// - Gated mode counts while gate pin high
// - Upper ignores gate; lower drives 32-bit
// - Gate falling edge ends count, keeps value
// - Upper match emits ADC trigger pulse
// - Prescaler divides by 1, 8, 64, 256
// - 32-bit mode uses lower prescaler only
// - Count or control writes clear prescaler
// - Disabled timer prescaler is not cleared
// - Control writes leave count unchanged
// - Sleep stops all counting
`default_nettype none

module timer_pair
	import timer_pair_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rstn,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [ADDR_W-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic i_cpu_idle,
	input wire logic i_cpu_sleep,
	input wire logic i_external_clock_gate_pin,
	input wire logic i_upper_external_clock_pin,
	output logic o_pready,
	output logic [31:0] o_prdata,
	output logic o_pslverr,
	output logic o_irq_upper,
	output logic o_irq_lower,
	output logic o_adc_trigger
);

	// ************************************************************
	// Decoding
	// ************************************************************
	function automatic reg_sel_t decode(input logic [ADDR_W-1:0] a);
		reg_sel_t s;
		s = SEL_NONE;
		if (a[1:0] == 2'h0) begin
			case (a[ADDR_W-1:2])
				IDX_LOW_COUNT_WORD: s = SEL_LOW_CNT;
				IDX_HIGH_WORD_HOLDING_REG: s = SEL_HOLD;
				IDX_HIGH_COUNT_WORD: s = SEL_HIGH_CNT;
				IDX_LOW_PERIOD_WORD: s = SEL_LOW_PER;
				IDX_HIGH_PERIOD_WORD: s = SEL_HIGH_PER;
				IDX_LOWER_TIMER_CONTROL: s = SEL_LOW_CTL;
				IDX_UPPER_TIMER_CONTROL: s = SEL_UP_CTL;
				IDX_IRQ_FLAGS_ENABLES: s = SEL_IRQ;
				default: s = SEL_NONE;
			endcase
		end
		return s;
	endfunction : decode

	function automatic logic [PSC_W-1:0] psc_limit(input logic [1:0] sel);
		logic [PSC_W-1:0] l;
		case (sel)
			2'h0: l = PSC_LIM_DIV1;
			2'h1: l = PSC_LIM_DIV8;
			2'h2: l = PSC_LIM_DIV64;
			default: l = PSC_LIM_DIV256;
		endcase
		return l;
	endfunction : psc_limit

	// ************************************************************
	// Register state
	// ************************************************************
	logic [15:0] ctl_reg [2];
	logic [CNT_W-1:0] low_count_word_reg, high_count_word_reg, high_word_holding_reg;
	logic [CNT_W-1:0] low_period_word_reg, high_period_word_reg;
	logic upper_timer_irq_flag_reg, lower_timer_irq_flag_reg;
	logic upper_timer_irq_enable_reg, lower_timer_irq_enable_reg;

	// ************************************************************
	// APB slave
	// ************************************************************
	reg_sel_t sel;
	logic access, rd_take, wr_do, wr_lo, wr_hi, wr_irq;
	logic [31:0] rdata_next;

	assign sel = decode(i_paddr);
	assign access = i_psel & i_penable;
	assign rd_take = access & ~o_pready & ~i_pwrite;
	assign wr_do = access & o_pready & i_pwrite;
	assign wr_lo = wr_do & (sel == SEL_LOW_CNT);
	assign wr_hi = wr_do & (sel == SEL_HIGH_CNT);
	assign wr_irq = wr_do & (sel == SEL_IRQ);

	always_comb begin
		rdata_next = 32'h0;
		case (sel)
			SEL_LOW_CNT: rdata_next[15:0] = low_count_word_reg;
			SEL_HOLD: rdata_next[15:0] = high_word_holding_reg;
			SEL_HIGH_CNT: rdata_next[15:0] = high_count_word_reg;
			SEL_LOW_PER: rdata_next[15:0] = low_period_word_reg;
			SEL_HIGH_PER: rdata_next[15:0] = high_period_word_reg;
			SEL_LOW_CTL: rdata_next[15:0] = ctl_reg[0];
			SEL_UP_CTL: rdata_next[15:0] = ctl_reg[1];
			SEL_IRQ: begin
				rdata_next[IRQ_UP_FLAG_BIT] = upper_timer_irq_flag_reg;
				rdata_next[IRQ_LO_FLAG_BIT] = lower_timer_irq_flag_reg;
				rdata_next[IRQ_UP_EN_BIT] = upper_timer_irq_enable_reg;
				rdata_next[IRQ_LO_EN_BIT] = lower_timer_irq_enable_reg;
			end
			default: rdata_next = 32'h0;
		endcase
	end

	// Answer one cycle into the access phase
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_pready <= 1'b0;
			o_prdata <= 32'h0;
			o_pslverr <= 1'b0;
		end else begin
			o_pready <= access & ~o_pready;
			if (access & ~o_pready) begin
				o_pslverr <= (sel == SEL_NONE);
				o_prdata <= i_pwrite ? 32'h0 : rdata_next;
			end
		end
	end

	// ************************************************************
	// Control, period and holding registers
	// ************************************************************
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			ctl_reg[0] <= CTL_RST;
			ctl_reg[1] <= CTL_RST;
			low_period_word_reg <= PERIOD_RST;
			high_period_word_reg <= PERIOD_RST;
		end else if (wr_do) begin
			case (sel)
				SEL_LOW_CTL: ctl_reg[0] <= i_pwdata[15:0] & LOWER_CTL_MASK;
				SEL_UP_CTL: ctl_reg[1] <= i_pwdata[15:0] & UPPER_CTL_MASK;
				SEL_LOW_PER: low_period_word_reg <= i_pwdata[15:0];
				SEL_HIGH_PER: high_period_word_reg <= i_pwdata[15:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			high_word_holding_reg <= COUNT_RST;
		end else if (rd_take & (sel == SEL_LOW_CNT)) begin
			high_word_holding_reg <= high_count_word_reg;
		end else if (wr_do & (sel == SEL_HOLD)) begin
			high_word_holding_reg <= i_pwdata[15:0];
		end
	end

	// ************************************************************
	// Pin synchronisers and prescalers
	// ************************************************************
	logic t32, gated0, tick_q, tick_lo, tick_hi16;
	logic pin [2], sync1 [2], sync2 [2], sync3 [2];
	logic active [2], src [2], psc_clr [2], psc_out [2];
	logic [PSC_W-1:0] pcnt [2];

	assign t32 = ctl_reg[0][CTL_T32_BIT];
	assign gated0 = ctl_reg[0][CTL_GATE_BIT] & ~ctl_reg[0][CTL_CS_BIT];
	assign pin[0] = i_external_clock_gate_pin;
	assign pin[1] = i_upper_external_clock_pin;

	for (genvar i = 0; i < 2; i++) begin : g_tmr
		logic run, wr_cnt, wr_ctl;
		assign run = ctl_reg[i][CTL_RUN_BIT];
		assign wr_cnt = (i == 0) ? (wr_lo | (t32 & wr_hi)) : wr_hi;
		assign wr_ctl = wr_do & (sel == ((i == 0) ? SEL_LOW_CTL : SEL_UP_CTL));
		// Upper unit is idle while cascaded
		assign active[i] = run & ~(i_cpu_idle & ctl_reg[i][CTL_SIDL_BIT])
			& ~i_cpu_sleep & ((i == 0) | ~t32);
		// External edges are always resynchronised
		assign src[i] = ctl_reg[i][CTL_CS_BIT] ? (sync2[i] & ~sync3[i])
			: (((i == 0) & gated0) ? sync2[i] : 1'b1);
		assign psc_clr[i] = run & (wr_cnt | wr_ctl);
		assign psc_out[i] = active[i] & src[i] & ~psc_clr[i]
			& (pcnt[i] >= psc_limit(ctl_reg[i][CTL_PSC_LSB +: 2]));

		always_ff @(posedge i_mclk or negedge i_rstn) begin
			if (!i_rstn) begin
				sync1[i] <= 1'b0;
				sync2[i] <= 1'b0;
				sync3[i] <= 1'b0;
			end else begin
				sync1[i] <= pin[i];
				sync2[i] <= sync1[i];
				sync3[i] <= sync2[i];
			end
		end

		always_ff @(posedge i_mclk or negedge i_rstn) begin
			if (!i_rstn) begin
				pcnt[i] <= '0;
			end else if (psc_clr[i]) begin
				pcnt[i] <= '0;
			end else if (active[i] & src[i]) begin
				pcnt[i] <= psc_out[i] ? '0 : pcnt[i] + 1'b1;
			end
		end
	end

	// Lower prescaler output is resampled before use
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			tick_q <= 1'b0;
		end else begin
			tick_q <= psc_out[0];
		end
	end

	assign tick_lo = tick_q & active[0] & ~wr_lo;
	assign tick_hi16 = psc_out[1] & ~t32;

	// ************************************************************
	// Counters
	// ************************************************************
	logic match32, match_lo, match_hi, evt_up, evt_lo, gate_fall;

	assign match_lo = low_count_word_reg == low_period_word_reg;
	assign match_hi = high_count_word_reg == high_period_word_reg;
	assign match32 = match_lo & match_hi;

	// Control writes never touch the count
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			low_count_word_reg <= COUNT_RST;
		end else if (wr_lo) begin
			low_count_word_reg <= i_pwdata[15:0];
		end else if (tick_lo & ~(t32 & wr_hi)) begin
			if (t32 ? match32 : match_lo) begin
				low_count_word_reg <= '0;
			end else begin
				low_count_word_reg <= low_count_word_reg + 1'b1;
			end
		end
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			high_count_word_reg <= COUNT_RST;
		end else if (wr_lo & t32) begin
			high_count_word_reg <= high_word_holding_reg;
		end else if (wr_hi) begin
			high_count_word_reg <= i_pwdata[15:0];
		end else if (t32 & tick_lo) begin
			if (match32) begin
				high_count_word_reg <= '0;
			end else if (&low_count_word_reg) begin
				high_count_word_reg <= high_count_word_reg + 1'b1;
			end
		end else if (tick_hi16) begin
			high_count_word_reg <= match_hi ? '0 : high_count_word_reg + 1'b1;
		end
	end

	// ************************************************************
	// Events, flags and outputs
	// ************************************************************
	assign evt_up = t32 ? (tick_lo & match32 & ~wr_hi) : (tick_hi16 & match_hi & ~wr_hi);
	assign evt_lo = ~t32 & tick_lo & match_lo;
	// Gate end stops counting and sets the lower flag, or the upper flag in 32-bit mode; value is kept
	assign gate_fall = ctl_reg[0][CTL_RUN_BIT] & gated0 & sync3[0] & ~sync2[0];

	// A set in the same cycle as a clear wins
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			upper_timer_irq_flag_reg <= 1'b0;
			lower_timer_irq_flag_reg <= 1'b0;
		end else begin
			upper_timer_irq_flag_reg <= (upper_timer_irq_flag_reg
				& ~(wr_irq & i_pwdata[IRQ_UP_FLAG_BIT])) | evt_up | (t32 & gate_fall);
			lower_timer_irq_flag_reg <= (lower_timer_irq_flag_reg
				& ~(wr_irq & i_pwdata[IRQ_LO_FLAG_BIT])) | evt_lo | (~t32 & gate_fall);
		end
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			upper_timer_irq_enable_reg <= 1'b0;
			lower_timer_irq_enable_reg <= 1'b0;
		end else if (wr_irq) begin
			upper_timer_irq_enable_reg <= i_pwdata[IRQ_UP_EN_BIT];
			lower_timer_irq_enable_reg <= i_pwdata[IRQ_LO_EN_BIT];
		end
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_irq_upper <= 1'b0;
			o_irq_lower <= 1'b0;
			o_adc_trigger <= 1'b0;
		end else begin
			o_irq_upper <= upper_timer_irq_flag_reg & upper_timer_irq_enable_reg;
			o_irq_lower <= lower_timer_irq_flag_reg & lower_timer_irq_enable_reg;
			o_adc_trigger <= evt_up;
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	property p_wrap32;
		@(posedge i_mclk) disable iff (!i_rstn)
		t32 && tick_lo && match32 && !wr_hi
		|=> {high_count_word_reg, low_count_word_reg} == 32'h0;
	endproperty
	a_wrap32: assert property (p_wrap32) else $error("32-bit count did not wrap");

	property p_inc32;
		@(posedge i_mclk) disable iff (!i_rstn)
		t32 && tick_lo && !match32 && !wr_hi
		|=> {high_count_word_reg, low_count_word_reg}
			== $past({high_count_word_reg, low_count_word_reg}) + 32'h1;
	endproperty
	a_inc32: assert property (p_inc32) else $error("32-bit count did not step");

	property p_hold32;
		@(posedge i_mclk) disable iff (!i_rstn)
		t32 && !tick_lo && !wr_lo && !wr_hi
		|=> $stable({high_count_word_reg, low_count_word_reg});
	endproperty
	a_hold32: assert property (p_hold32) else $error("32-bit count moved without tick");

	property p_irq_up;
		@(posedge i_mclk) disable iff (!i_rstn)
		evt_up && upper_timer_irq_enable_reg && !wr_irq |=> ##1 o_irq_upper;
	endproperty
	a_irq_up: assert property (p_irq_up) else $error("Upper interrupt not raised");

	property p_capture;
		@(posedge i_mclk) disable iff (!i_rstn)
		rd_take && sel == SEL_LOW_CNT |=> high_word_holding_reg == $past(high_count_word_reg);
	endproperty
	a_capture: assert property (p_capture) else $error("High word not captured");
	property p_load_hi;
		@(posedge i_mclk) disable iff (!i_rstn)
		wr_lo && t32 |=> high_count_word_reg == $past(high_word_holding_reg);
	endproperty
	a_load_hi: assert property (p_load_hi) else $error("Held word not loaded");
	property p_idle;
		@(posedge i_mclk) disable iff (!i_rstn)
		i_cpu_idle && ctl_reg[0][CTL_SIDL_BIT] && !wr_lo && !wr_hi
		|=> $stable(low_count_word_reg);
	endproperty
	a_idle: assert property (p_idle) else $error("Counted during idle");
	property p_idle_hi;
		@(posedge i_mclk) disable iff (!i_rstn)
		i_cpu_idle && ctl_reg[1][CTL_SIDL_BIT] && !t32 && !wr_hi |=> $stable(high_count_word_reg);
	endproperty
	a_idle_hi: assert property (p_idle_hi) else $error("Upper counted during idle");
	property p_gate_low;
		@(posedge i_mclk) disable iff (!i_rstn)
		gated0 && $past(gated0) && !sync2[0] && $past(!sync2[0]) && !wr_lo && !wr_hi
		|=> $stable(low_count_word_reg);
	endproperty
	a_gate_low: assert property (p_gate_low) else $error("Counted with gate low");
	property p_adc;
		@(posedge i_mclk) disable iff (!i_rstn)
		evt_up |=> o_adc_trigger ##1 !o_adc_trigger || $past(evt_up, 1);
	endproperty
	a_adc: assert property (p_adc) else $error("ADC trigger not pulsed");
	property p_psc_clr;
		@(posedge i_mclk) disable iff (!i_rstn)
		wr_do && sel == SEL_LOW_CTL && ctl_reg[0][CTL_RUN_BIT] |=> pcnt[0] == '0;
	endproperty
	a_psc_clr: assert property (p_psc_clr) else $error("Prescaler not cleared");

endmodule : timer_pair

`default_nettype wire

/* bench/clock_gate_source.sv */
/*
 * Model of the source that drives the external clock and gate pins.
 * Assumes the bench clock; the clock stands low while not running.
 */
`default_nettype none

module clock_gate_source #(
	parameter int HALF = 3
) (
	input wire logic i_mclk,
	input wire logic i_rstn,
	input wire logic i_clk_run,
	input wire logic i_gate,
	output logic o_pin_lower,
	output logic o_pin_upper
);
	timeunit 1ns;
	timeprecision 1ns;

	// ************************************************************
	// Clock toggling
	// ************************************************************
	int div_reg;
	logic tog_reg;

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			div_reg <= 0;
			tog_reg <= 1'b0;
		end else if (!i_clk_run) begin
			div_reg <= 0;
			tog_reg <= 1'b0;
		end else if (div_reg == HALF - 1) begin
			div_reg <= 0;
			tog_reg <= ~tog_reg;
		end else begin
			div_reg <= div_reg + 1;
		end
	end

	assign o_pin_lower = tog_reg | i_gate;
	assign o_pin_upper = tog_reg;
endmodule : clock_gate_source

`default_nettype wire

/* bench/dual_16_or_32bit_timer_pair_bench.sv */
/*
 * Self-checking bench of the timer pair: APB tasks, period, prescaler,
 * cascade, holding word, gating, idle and sleep scenarios.
 * Assumes the clock and gate source model drives both external pins.
 */
`default_nettype none

module dual_16_or_32bit_timer_pair_bench
	import timer_pair_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ns;

	// ************************************************************
	// Signals and instances
	// ************************************************************
	logic mclk, rstn, psel, penable, pwrite, idle, sleep, clk_run, gate;
	logic [ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, rnd, v;
	logic pready, pslverr, irq_up, irq_lo, adc, pin_lo, pin_up;
	logic [32:0] exp_q[$];
	int errors = 0;
	int compares = 0;
	int divs[4] = '{1, 8, 64, 256};

	timer_pair i_timer_pair (.i_mclk(mclk), .i_rstn(rstn), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.i_cpu_idle(idle), .i_cpu_sleep(sleep), .i_external_clock_gate_pin(pin_lo),
		.i_upper_external_clock_pin(pin_up), .o_pready(pready), .o_prdata(prdata),
		.o_pslverr(pslverr), .o_irq_upper(irq_up), .o_irq_lower(irq_lo),
		.o_adc_trigger(adc));

	clock_gate_source i_clock_gate_source (.i_mclk(mclk), .i_rstn(rstn),
		.i_clk_run(clk_run), .i_gate(gate), .o_pin_lower(pin_lo), .o_pin_upper(pin_up));

	// ************************************************************
	// Tasks
	// ************************************************************
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic chk(input string what, input logic [32:0] exp, input logic [32:0] got);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic apb(input logic wr, input logic [9:0] idx, input logic [15:0] d,
			input logic [32:0] exp);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= {16'h0000, d};
		if (!wr) exp_q.push_back(exp);
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk iff pready === 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rd(input logic [9:0] idx, input logic [15:0] d, input logic err = 1'b0);
		apb(1'b0, idx, 16'h0000, {err, 16'h0000, d});
	endtask : rd

	task automatic wr(input logic [9:0] idx, input logic [15:0] d);
		apb(1'b1, idx, d, 33'h0);
	endtask : wr

	task automatic cfg(input logic [15:0] lo_ctl, up_ctl, per_lo, per_hi);
		wr(IDX_UPPER_TIMER_CONTROL, 16'h0000);
		wr(IDX_LOWER_TIMER_CONTROL, 16'h0000);
		wr(IDX_LOW_COUNT_WORD, 16'h0000);
		wr(IDX_HIGH_COUNT_WORD, 16'h0000);
		wr(IDX_LOW_PERIOD_WORD, per_lo);
		wr(IDX_HIGH_PERIOD_WORD, per_hi);
		wr(IDX_IRQ_FLAGS_ENABLES, 16'h0303);
		wr(IDX_LOWER_TIMER_CONTROL, lo_ctl);
		wr(IDX_UPPER_TIMER_CONTROL, up_ctl);
	endtask : cfg

	task automatic gap(input int exp, input int kind);
		time t0;
		@(posedge mclk iff adc === 1'b1);
		t0 = $time;
		idle <= (kind == 1);
		sleep <= (kind == 2);
		if (kind != 0) repeat (20) @(posedge mclk);
		idle <= 1'b0;
		sleep <= 1'b0;
		@(posedge mclk iff adc === 1'b1);
		chk("adc gap", 33'(exp), 33'(($time - t0) / 50));
	endtask : gap

	task automatic finish_test;
		$display("Comparisons %0d, errors %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : finish_test

	// ************************************************************
	// Read watcher, clock and watchdog
	// ************************************************************
	always @(posedge mclk) begin
		if (psel && penable && !pwrite && pready === 1'b1) begin
			chk("read data", exp_q.pop_front(), {pslverr, prdata});
		end
	end

	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	initial begin
		repeat (30000) @(posedge mclk);
		errors++;
		finish_test();
	end

	// ************************************************************
	// Scenarios
	// ************************************************************
	initial begin
		{rstn, psel, penable, pwrite, idle, sleep, clk_run, gate} = 8'h00;
		paddr = '0;
		pwdata = 32'h00000000;
		rnd = 32'h0001185a;
		repeat (10) @(posedge mclk);
		rstn <= 1'b1;
		rd(IDX_LOW_COUNT_WORD, COUNT_RST);
		rd(IDX_HIGH_COUNT_WORD, COUNT_RST);
		rd(IDX_LOW_PERIOD_WORD, PERIOD_RST);
		rd(IDX_HIGH_PERIOD_WORD, PERIOD_RST);
		rd(IDX_LOWER_TIMER_CONTROL, CTL_RST);
		rd(IDX_UPPER_TIMER_CONTROL, CTL_RST);
		rd(IDX_IRQ_FLAGS_ENABLES, 16'h0000);
		rd(10'h130, 16'h0000, 1'b1);
		for (int k = 0; k < 3; k++) begin
			wr(IDX_LOWER_TIMER_CONTROL, 16'h0008);
			v = lfsr(rnd);
			rnd = lfsr(v);
			wr(IDX_HIGH_WORD_HOLDING_REG, v[31:16]);
			wr(IDX_LOW_COUNT_WORD, v[15:0]);
			rd(IDX_HIGH_COUNT_WORD, v[31:16]);
			wr(IDX_HIGH_COUNT_WORD, rnd[15:0]);
			rd(IDX_LOW_COUNT_WORD, v[15:0]);
			rd(IDX_HIGH_WORD_HOLDING_REG, rnd[15:0]);
			wr(IDX_LOWER_TIMER_CONTROL, 16'h0038);
			rd(IDX_LOW_COUNT_WORD, v[15:0]);
		end
		for (int ps = 0; ps < 4; ps++) begin
			cfg(16'h0000, 16'h8000 | 16'(ps << 4), 16'h0002, 16'h0002);
			gap(3 * divs[ps], 0);
			cfg(16'h8008 | 16'(ps << 4), 16'h8070, 16'h0002, 16'h0000);
			gap(3 * divs[ps], 0);
		end
		wr(IDX_UPPER_TIMER_CONTROL, 16'h0000);
		wr(IDX_LOWER_TIMER_CONTROL, 16'h0000);
		rd(IDX_IRQ_FLAGS_ENABLES, 16'h0301);
		chk("irq upper", 33'h1, 33'(irq_up));
		chk("irq lower", 33'h0, 33'(irq_lo));
		wr(IDX_IRQ_FLAGS_ENABLES, 16'h0301);
		rd(IDX_IRQ_FLAGS_ENABLES, 16'h0300);
		chk("irq upper", 33'h0, 33'(irq_up));
		for (int c = 0; c < 3; c++) begin
			cfg(16'h0000, (c == 0) ? 16'ha000 : 16'h8000, 16'hffff, 16'h001d);
			gap((c == 1) ? 30 : 50, (c == 2) ? 2 : 1);
		end
		clk_run <= 1'b1;
		cfg(16'h800a, 16'h0000, 16'h0004, 16'h0000);
		gap(30, 0);
		cfg(16'h0000, 16'h8002, 16'hffff, 16'h0004);
		gap(30, 0);
		clk_run <= 1'b0;
		cfg(16'h8040, 16'h0000, 16'hffff, 16'hffff);
		repeat (5) @(posedge mclk);
		rd(IDX_LOW_COUNT_WORD, 16'h0000);
		gate <= 1'b1;
		repeat (37) @(posedge mclk);
		gate <= 1'b0;
		repeat (10) @(posedge mclk);
		rd(IDX_LOW_COUNT_WORD, 16'h0025);
		rd(IDX_IRQ_FLAGS_ENABLES, 16'h0302);
		chk("irq lower", 33'h1, 33'(irq_lo));
		repeat (20) @(posedge mclk);
		rd(IDX_LOW_COUNT_WORD, 16'h0025);
		cfg(16'h8048, 16'h0000, 16'hffff, 16'hffff);
		gate <= 1'b1;
		repeat (10) @(posedge mclk);
		gate <= 1'b0;
		repeat (10) @(posedge mclk);
		rd(IDX_LOW_COUNT_WORD, 16'h000a);
		rd(IDX_IRQ_FLAGS_ENABLES, 16'h0301);
		chk("irq upper", 33'h1, 33'(irq_up));
		repeat (3) @(posedge mclk);
		finish_test();
	end
endmodule : dual_16_or_32bit_timer_pair_bench

`default_nettype wire
